// [bench/ppc_pad_config_asserts.sv]
// Concurrent checks on the pad configuration block's ports.
// Assumes it is bound to ppc_pad_config; one clock domain, sys_clk.
`timescale 1ns/1ps
`default_nettype none

module ppc_pad_config_asserts (
    input wire logic        sys_clk,        // Core clock
    input wire logic        nrst,           // Reset, active low
    input wire logic        ce,             // Clock enable
    input wire logic [12:0] reg_addr,       // Register address
    input wire logic [7:0]  reg_wdata,      // Write data
    input wire logic        reg_wr,         // Write strobe
    input wire logic        reg_rd,         // Read strobe
    input wire logic [7:0]  reg_rdata,      // Read data
    input wire logic        batt_backup_en, // Battery backup enable
    input wire logic [7:0]  pa_dir_in,      // Port A direction
    input wire logic [7:0]  pa_data,        // Port A data
    input wire logic [7:0]  pd_dir_in,      // Port D direction
    input wire logic [7:0]  pa_pad_out,     // Port A pad level
    input wire logic [7:0]  pa_pad_oe,      // Port A drive enable
    input wire logic [7:0]  pa_pullup,      // Port A pull-up
    input wire logic [7:0]  pd_pullup       // Port D pull-up
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire wr_ok = ce & reg_wr;
    wire rd_ok = ce & reg_rd;

    a_pullup_follow: assert property (wr_ok && reg_addr == 13'h1F40 |=> pa_pullup ==
        ($past(reg_wdata) & pa_dir_in & (batt_backup_en ? 8'hFF : 8'hDF)))
        else $error("port A pull-up does not follow its enable");
    a_pullup_output: assert property (((pa_pullup & ~pa_dir_in) | (pd_pullup & ~pd_dir_in)) == 8'h00)
        else $error("pull-up on while pin is output");
    a_a5_battery: assert property (!batt_backup_en |-> !pa_pullup[5])
        else $error("pin A5 pull-up on without battery backup");
    a_od_sink: assert property (wr_ok && reg_addr == 13'h1F41 |=> pa_pad_oe ==
        (~pa_dir_in & ~($past(reg_wdata) & 8'hDF & pa_data)))
        else $error("open-drain drive enable wrong");
    a_push_pull: assert property (wr_ok && reg_addr == 13'h1F41 |=>
        pa_pad_out == (pa_data & ~($past(reg_wdata) & 8'hDF)))
        else $error("push-pull pad level wrong");
    a_unmapped_zero: assert property (rd_ok && (reg_addr == 13'h1F56 || reg_addr == 13'h1F5E)
        |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    a_unimpl_bit: assert property (rd_ok && reg_addr == 13'h1F41 |=> !reg_rdata[5])
        else $error("unimplemented bit read as one");
    a_reset_clear: assert property ($rose(nrst) |-> pa_pullup == 8'h00 && pa_pad_oe == ~pa_dir_in)
        else $error("pad settings not cleared by reset");
    a_d_write: assert property (wr_ok && reg_addr == 13'h1F5A |=>
        pd_pullup == ($past(reg_wdata) & pd_dir_in))
        else $error("port D pull-up late after write");
    a_read_back: assert property (wr_ok && reg_addr == 13'h1F5B ##1 rd_ok && reg_addr == 13'h1F5B
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("read after write returns old value");
endmodule // ppc_pad_config_asserts

`default_nettype wire

// [bench/ppc_pad_config_tb.sv]
// Self-checking bench for the pad configuration block: register map and pad decode.
// Assumes ppc_pad_config and the checker module are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module ppc_pad_config_tb;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        ce = 1'b1;
    logic [12:0] reg_addr = 13'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        batt_backup_en = 1'b1;
    logic [7:0]  pa_dir_in = 8'hFF, pa_data = 8'h00, pc_dir_in = 8'hFF, pc_data = 8'h00;
    logic [7:0]  pd_dir_in = 8'hFF, pd_data = 8'h00, pb_pad_in = 8'h00, pc_pad_in = 8'h00;
    logic [7:0]  rnd = 8'h5B;
    wire  [7:0]  reg_rdata, pa_pad_out, pa_pad_oe, pa_pullup, pd_pullup;
    wire  [7:0]  pb_pad_oe, pb_pullup, pd_pad_oe;
    wire         pc_change_any;
    int          n_tests = 0;
    int          err_count = 0;
    int          cyc = 0;
    logic [12:0] ra [23] = '{13'h1F40, 13'h1F41, 13'h1F43, 13'h1F44, 13'h1F45, 13'h1F46,
        13'h1F47, 13'h1F48, 13'h1F49, 13'h1F4A, 13'h1F4E, 13'h1F4F, 13'h1F50, 13'h1F51,
        13'h1F52, 13'h1F53, 13'h1F54, 13'h1F55, 13'h1F59, 13'h1F5A, 13'h1F5B, 13'h1F5C, 13'h1F5D};
    logic [7:0]  rv [23] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF,
        8'h00, 8'hDF, 8'h00, 8'h00, 8'hDF, 8'hDF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
        8'hFF, 8'hFF};
    // Change flags stay clear while port C pads are held still, so they read zero
    logic [7:0]  rm [23] = '{8'hFF, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h02, 8'hDF, 8'hDF, 8'hDF, 8'hDF, 8'hDF, 8'hDF, 8'hDF, 8'h00, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF};

    ppc_pad_config dut (.sys_clk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .batt_backup_en, .pa_dir_in, .pa_data, .pc_dir_in, .pc_data, .pd_dir_in,
        .pd_data, .pb_pad_in, .pc_pad_in, .pa_pad_out, .pa_pad_oe, .pa_pullup, .pb_pad_out(),
        .pb_pad_oe, .pb_pullup, .pb_analog(), .pb_slew(), .pb_inlvl(), .pb_high_drive(),
        .pc_pad_out(), .pc_pad_oe(), .pc_pullup(), .pc_analog(), .pc_slew(), .pc_inlvl(),
        .pc_change_any, .pd_pad_out(), .pd_pad_oe, .pd_pullup, .pd_analog(), .pd_slew(),
        .pd_inlvl());

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] exp_pu(input logic [7:0] w, d, input logic b);
        return w & d & (b ? 8'hFF : 8'hDF);
    endfunction
    function automatic logic [7:0] exp_oe(input logic [7:0] o, d, v);
        return ~d & ~(o & 8'hDF & v);
    endfunction

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Strobes are re-driven on every call, so back-to-back calls never assign twice
    task automatic bus(input logic w, r, input logic [12:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] exp);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        check("read data", reg_rdata, exp); // Register read-back
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        logic [7:0] w, o;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 23; i++) rd(ra[i], rv[i]);
        $display("reset values done");
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 23; i++) begin
                rnd = lfsr(rnd);
                bus(1'b1, 1'b0, ra[i], rnd);
                rd(ra[i], rnd & rm[i]);
            end
        end
        bus(1'b1, 1'b0, 13'h1F56, 8'hFF);
        rd(13'h1F56, 8'h00);
        bus(1'b1, 1'b0, 13'h1F5E, 8'hA5);
        rd(13'h1F5E, 8'h00);
        $display("register access done");
        for (int k = 0; k < 20; k++) begin
            rnd = lfsr(rnd);
            w = (k == 0) ? 8'hFF : rnd;
            rnd = lfsr(rnd);
            o = rnd;
            bus(1'b1, 1'b0, 13'h1F40, w);
            bus(1'b1, 1'b0, 13'h1F41, o);
            bus(1'b1, 1'b0, 13'h1F5A, w);
            bus(1'b1, 1'b0, 13'h1F5B, o);
            rnd = lfsr(rnd);
            pa_dir_in <= (k == 0) ? 8'hFF : rnd;
            pd_dir_in <= ~rnd;
            pc_dir_in <= rnd;
            rnd = lfsr(rnd);
            pa_data <= rnd;
            pc_data <= ~rnd;
            pd_data <= rnd;
            pb_pad_in <= rnd;
            pc_pad_in <= ~rnd;
            batt_backup_en <= (k < 2) ? 1'b0 : rnd[0];
            bus(1'b0, 1'b0, 13'h0000, 8'h00);
            check("pa pull-up", pa_pullup, exp_pu(w, pa_dir_in, batt_backup_en));
            check("pa drive enable", pa_pad_oe, exp_oe(o, pa_dir_in, pa_data));
            check("pa pad level", pa_pad_out, pa_data & ~(o & 8'hDF));
            check("pd pull-up", pd_pullup, exp_pu(w, pd_dir_in, 1'b1));
            check("pd drive enable", pd_pad_oe, ~pd_dir_in & ~(o & pd_data));
        end
        $display("pad decode done");
        bus(1'b1, 1'b0, 13'h1F43, 8'h0F);
        bus(1'b1, 1'b0, 13'h1F46, 8'hFF);
        bus(1'b1, 1'b0, 13'h1F47, 8'h00);
        bus(1'b1, 1'b0, 13'h1F44, 8'h00);
        bus(1'b0, 1'b0, 13'h0000, 8'h00);
        check("pb pull-up", pb_pullup, 8'h0F);
        check("pb drive enable", pb_pad_oe, 8'hF0);
        rd(13'h1F42, pb_pad_in);
        bus(1'b1, 1'b0, 13'h1F5A, 8'h00);
        ce <= 1'b0;
        bus(1'b1, 1'b0, 13'h1F5A, 8'h3C);
        ce <= 1'b1;
        rd(13'h1F5A, 8'h00);
        pc_pad_in <= 8'h00;
        repeat (4) bus(1'b0, 1'b0, 13'h0000, 8'h00);
        bus(1'b1, 1'b0, 13'h1F53, 8'h01);
        bus(1'b1, 1'b0, 13'h1F54, 8'h00);
        bus(1'b1, 1'b0, 13'h1F55, 8'h00);
        rd(13'h1F55, 8'h00);
        check("change flag idle", {7'h00, pc_change_any}, 8'h00);
        pc_pad_in <= 8'h01;
        repeat (4) bus(1'b0, 1'b0, 13'h0000, 8'h00);
        check("change flag set", {7'h00, pc_change_any}, 8'h01);
        rd(13'h1F55, 8'h01);
        bus(1'b1, 1'b0, 13'h1F55, 8'h00);
        rd(13'h1F55, 8'h00);
        $display("port B, enable and change detect done");
        nrst <= 1'b0;
        bus(1'b0, 1'b0, 13'h0000, 8'h00);
        bus(1'b0, 1'b0, 13'h0000, 8'h00);
        check("pa pull-up in reset", pa_pullup, 8'h00);
        check("pa drive in reset", pa_pad_oe, ~pa_dir_in);
        nrst <= 1'b1;
        repeat (3) bus(1'b0, 1'b0, 13'h0000, 8'h00);
        rd(13'h1F41, 8'h00);
        rd(13'h1F5A, 8'h00);
        $display("mid-run reset done");
        give_verdict();
    end
endmodule // ppc_pad_config_tb

bind ppc_pad_config ppc_pad_config_asserts u_chk (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .batt_backup_en(batt_backup_en), .pa_dir_in(pa_dir_in),
    .pa_data(pa_data), .pd_dir_in(pd_dir_in), .pa_pad_out(pa_pad_out), .pa_pad_oe(pa_pad_oe),
    .pa_pullup(pa_pullup), .pd_pullup(pd_pullup));

`default_nettype wire

// [common/ppc_defines.vh]
// Constants for the port pad configuration block: offsets, masks, reset values.
// Assumes an 8-bit register port addressed by 13-bit data-memory addresses.
// Operation
// - Port A pull-up bit enables pin pull-up
// - Pull-up forced off while pin is output
// - Pin A5 pull-up ignored without battery backup
// - Open-drain bit set: pin only sinks current
// - Open-drain bit clear: pin drives push-pull
// - Unimplemented bits, addresses read zero, ignore writes
// - Pull-up, open-drain bits clear on reset
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH

`define PPC_AW 13
`define PPC_DW 8

`define PPC_A_WPU     13'h1F40
`define PPC_A_ODCON   13'h1F41
`define PPC_B_PINS    13'h1F42
`define PPC_B_DIR     13'h1F43
`define PPC_B_LAT     13'h1F44
`define PPC_B_ANSEL   13'h1F45
`define PPC_B_WPU     13'h1F46
`define PPC_B_ODCON   13'h1F47
`define PPC_B_SLEW    13'h1F48
`define PPC_B_INLVL   13'h1F49
`define PPC_B_HIDRV   13'h1F4A
`define PPC_C_ANSEL   13'h1F4E
`define PPC_C_WPU     13'h1F4F
`define PPC_C_ODCON   13'h1F50
`define PPC_C_SLEW    13'h1F51
`define PPC_C_INLVL   13'h1F52
`define PPC_C_RISE    13'h1F53
`define PPC_C_FALL    13'h1F54
`define PPC_C_FLAGS   13'h1F55
`define PPC_D_ANSEL   13'h1F59
`define PPC_D_WPU     13'h1F5A
`define PPC_D_ODCON   13'h1F5B
`define PPC_D_SLEW    13'h1F5C
`define PPC_D_INLVL   13'h1F5D

`define PPC_MASK_ALL  8'hFF
`define PPC_MASK_A_OD 8'hDF
`define PPC_MASK_C    8'hDF
`define PPC_MASK_HID  8'h02
`define PPC_A5_BIT    5

`define PPC_RST_ZERO  8'h00
`define PPC_RST_ONES  8'hFF
`define PPC_RST_C_ONE 8'hDF

`endif

// [verilog/ppc_pad_config.v]
// Pad configuration registers for ports A to D and their pad drive decode.
// Assumes pad inputs arrive asynchronously; direction and data of ports A, C
// and D come from port logic on sys_clk.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.vh"

module ppc_pad_config (
    input  wire                sys_clk,        // Core clock, 100 MHz
    input  wire                nrst,           // Async reset, active low
    input  wire                ce,             // Clock enable, freezes state
    input  wire [`PPC_AW-1:0]  reg_addr,       // Register address
    input  wire [`PPC_DW-1:0]  reg_wdata,      // Write data
    input  wire                reg_wr,         // Write strobe
    input  wire                reg_rd,         // Read strobe
    output reg  [`PPC_DW-1:0]  reg_rdata,      // Read data, cycle after strobe
    input  wire                batt_backup_en, // Battery backup enable setting
    input  wire [7:0]          pa_dir_in,      // Port A: 1 = pin is input
    input  wire [7:0]          pa_data,        // Port A output data
    input  wire [7:0]          pc_dir_in,      // Port C: 1 = pin is input
    input  wire [7:0]          pc_data,        // Port C output data
    input  wire [7:0]          pd_dir_in,      // Port D: 1 = pin is input
    input  wire [7:0]          pd_data,        // Port D output data
    input  wire [7:0]          pb_pad_in,      // Port B pad levels, async
    input  wire [7:0]          pc_pad_in,      // Port C pad levels, async
    output wire [7:0]          pa_pad_out,     // Port A pad output level
    output wire [7:0]          pa_pad_oe,      // Port A pad drive enable
    output wire [7:0]          pa_pullup,      // Port A weak pull-up on
    output wire [7:0]          pb_pad_out,     // Port B pad output level
    output wire [7:0]          pb_pad_oe,      // Port B pad drive enable
    output wire [7:0]          pb_pullup,      // Port B weak pull-up on
    output wire [7:0]          pb_analog,      // Port B analog select
    output wire [7:0]          pb_slew,        // Port B slew limit
    output wire [7:0]          pb_inlvl,       // Port B input threshold
    output wire [7:0]          pb_high_drive,  // Port B high drive
    output wire [7:0]          pc_pad_out,     // Port C pad output level
    output wire [7:0]          pc_pad_oe,      // Port C pad drive enable
    output wire [7:0]          pc_pullup,      // Port C weak pull-up on
    output wire [7:0]          pc_analog,      // Port C analog select
    output wire [7:0]          pc_slew,        // Port C slew limit
    output wire [7:0]          pc_inlvl,       // Port C input threshold
    output wire                pc_change_any,  // Any port C change flag set
    output wire [7:0]          pd_pad_out,     // Port D pad output level
    output wire [7:0]          pd_pad_oe,      // Port D pad drive enable
    output wire [7:0]          pd_pullup,      // Port D weak pull-up on
    output wire [7:0]          pd_analog,      // Port D analog select
    output wire [7:0]          pd_slew,        // Port D slew limit
    output wire [7:0]          pd_inlvl        // Port D input threshold
);

    // Pull-up only on input pins
    function [7:0] pull_on;
        input [7:0] wpu;
        input [7:0] dir_in;
        begin
            pull_on = wpu & dir_in;
        end
    endfunction

    // Open-drain pins drive only a low; push-pull pins drive both levels
    function [7:0] drive_en;
        input [7:0] dir_in;
        input [7:0] data;
        input [7:0] od;
        begin
            drive_en = ~dir_in & (~od | ~data);
        end
    endfunction

    function [7:0] drive_lvl;
        input [7:0] data;
        input [7:0] od;
        begin
            drive_lvl = data & ~od;
        end
    endfunction

    // Bits that exist at each address; the rest read zero and ignore writes
    function [7:0] impl_mask;
        input [`PPC_AW-1:0] addr;
        begin
            case (addr)
                `PPC_A_ODCON: impl_mask = `PPC_MASK_A_OD;
                `PPC_B_HIDRV: impl_mask = `PPC_MASK_HID;
                `PPC_C_ANSEL, `PPC_C_WPU, `PPC_C_ODCON, `PPC_C_SLEW,
                `PPC_C_INLVL, `PPC_C_RISE, `PPC_C_FALL, `PPC_C_FLAGS:
                    impl_mask = `PPC_MASK_C;
                default:      impl_mask = `PPC_MASK_ALL;
            endcase
        end
    endfunction

    // Reset release and pad synchronisers
    reg        rst_meta_ff;    // Reset release, first stage
    reg        rst_sync_ff;    // Reset release, second stage
    wire       rst_n = rst_sync_ff;
    reg  [7:0] pb_meta_ff;     // Port B pads, first stage
    reg  [7:0] pb_sync_ff;     // Port B pads, second stage
    reg  [7:0] pc_meta_ff;     // Port C pads, first stage
    reg  [7:0] pc_sync_ff;     // Port C pads, second stage
    reg  [7:0] pc_prev_ff;     // Port C pads, one cycle older

    // Port A
    reg  [7:0] a_wpu_ff;       // Pull-up enables
    reg  [7:0] a_od_ff;        // Open-drain selects
    // Port B
    reg  [7:0] b_dir_ff;       // Direction, 1 = input
    reg  [7:0] b_lat_ff;       // Output latch
    reg  [7:0] b_ansel_ff;     // Analog select
    reg  [7:0] b_wpu_ff;       // Pull-up enables
    reg  [7:0] b_od_ff;        // Open-drain selects
    reg  [7:0] b_slew_ff;      // Slew limit
    reg  [7:0] b_inlvl_ff;     // Input threshold
    reg  [7:0] b_hid_ff;       // High drive, bit 1 only
    // Port C
    reg  [7:0] c_ansel_ff;     // Analog select
    reg  [7:0] c_wpu_ff;       // Pull-up enables
    reg  [7:0] c_od_ff;        // Open-drain selects
    reg  [7:0] c_slew_ff;      // Slew limit
    reg  [7:0] c_inlvl_ff;     // Input threshold
    reg  [7:0] c_rise_ff;      // Rising edge detect enables
    reg  [7:0] c_fall_ff;      // Falling edge detect enables
    reg  [7:0] c_flags_ff;     // Change flags
    // Port D
    reg  [7:0] d_ansel_ff;     // Analog select
    reg  [7:0] d_wpu_ff;       // Pull-up enables
    reg  [7:0] d_od_ff;        // Open-drain selects
    reg  [7:0] d_slew_ff;      // Slew limit
    reg  [7:0] d_inlvl_ff;     // Input threshold
    reg  [7:0] nxt_c_flags;    // Change flags, next value
    reg  [7:0] nxt_rdata;      // Read mux output

    // Write data is masked once here, so no register can hold a missing bit
    wire       wr = ce & reg_wr;
    wire [7:0] wd = reg_wdata & impl_mask(reg_addr);

    // Reset release through two flops; assertion stays asynchronous
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pb_meta_ff <= `PPC_RST_ZERO;
            pb_sync_ff <= `PPC_RST_ZERO;
            pc_meta_ff <= `PPC_RST_ZERO;
            pc_sync_ff <= `PPC_RST_ZERO;
            pc_prev_ff <= `PPC_RST_ZERO;
        end else if (ce) begin
            pb_meta_ff <= pb_pad_in;
            pb_sync_ff <= pb_meta_ff;
            pc_meta_ff <= pc_pad_in;
            pc_sync_ff <= pc_meta_ff;
            pc_prev_ff <= pc_sync_ff;
        end
    end

    // Enabled edges on the synchronised port C pads
    wire [7:0] c_rise_hit = c_rise_ff & pc_sync_ff & ~pc_prev_ff;
    wire [7:0] c_fall_hit = c_fall_ff & ~pc_sync_ff & pc_prev_ff;

    // Change flags: a new edge wins over a software clear in the same cycle,
    // so an edge is never lost to a clear that raced it
    always @* begin
        nxt_c_flags = c_flags_ff;
        if (wr && reg_addr == `PPC_C_FLAGS)
            nxt_c_flags = c_flags_ff & wd;
        nxt_c_flags = (nxt_c_flags | c_rise_hit | c_fall_hit) & `PPC_MASK_C;
    end

    // Port A; every write path is gated by the clock enable through wr
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_wpu_ff <= `PPC_RST_ZERO;
            a_od_ff  <= `PPC_RST_ZERO;
        end else if (wr) begin
            case (reg_addr)
                `PPC_A_WPU:   a_wpu_ff <= wd;
                `PPC_A_ODCON: a_od_ff  <= wd;
                default: ;
            endcase
        end
    end

    // Port B: the pins address writes the latch but reads the pads, so read-modify-write
    // of the pins copies a pad level that another driver forced into the latch
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            b_dir_ff   <= `PPC_RST_ONES;
            b_lat_ff   <= `PPC_RST_ZERO;
            b_ansel_ff <= `PPC_RST_ONES;
            b_wpu_ff   <= `PPC_RST_ZERO;
            b_od_ff    <= `PPC_RST_ZERO;
            b_slew_ff  <= `PPC_RST_ONES;
            b_inlvl_ff <= `PPC_RST_ONES;
            b_hid_ff   <= `PPC_RST_ZERO;
        end else if (wr) begin
            case (reg_addr)
                `PPC_B_PINS:  b_lat_ff   <= wd;
                `PPC_B_DIR:   b_dir_ff   <= wd;
                `PPC_B_LAT:   b_lat_ff   <= wd;
                `PPC_B_ANSEL: b_ansel_ff <= wd;
                `PPC_B_WPU:   b_wpu_ff   <= wd;
                `PPC_B_ODCON: b_od_ff    <= wd;
                `PPC_B_SLEW:  b_slew_ff  <= wd;
                `PPC_B_INLVL: b_inlvl_ff <= wd;
                `PPC_B_HIDRV: b_hid_ff   <= wd;
                default: ;
            endcase
        end
    end

    // Port C: flags advance on every enabled cycle, settings only on a write
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            c_ansel_ff <= `PPC_RST_C_ONE;
            c_wpu_ff   <= `PPC_RST_ZERO;
            c_od_ff    <= `PPC_RST_ZERO;
            c_slew_ff  <= `PPC_RST_C_ONE;
            c_inlvl_ff <= `PPC_RST_C_ONE;
            c_rise_ff  <= `PPC_RST_ZERO;
            c_fall_ff  <= `PPC_RST_ZERO;
            c_flags_ff <= `PPC_RST_ZERO;
        end else if (ce) begin
            c_flags_ff <= nxt_c_flags;
            if (wr) begin
                case (reg_addr)
                    `PPC_C_ANSEL: c_ansel_ff <= wd;
                    `PPC_C_WPU:   c_wpu_ff   <= wd;
                    `PPC_C_ODCON: c_od_ff    <= wd;
                    `PPC_C_SLEW:  c_slew_ff  <= wd;
                    `PPC_C_INLVL: c_inlvl_ff <= wd;
                    `PPC_C_RISE:  c_rise_ff  <= wd;
                    `PPC_C_FALL:  c_fall_ff  <= wd;
                    default: ;
                endcase
            end
        end
    end

    // Port D
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            d_ansel_ff <= `PPC_RST_ONES;
            d_wpu_ff   <= `PPC_RST_ZERO;
            d_od_ff    <= `PPC_RST_ZERO;
            d_slew_ff  <= `PPC_RST_ONES;
            d_inlvl_ff <= `PPC_RST_ONES;
        end else if (wr) begin
            case (reg_addr)
                `PPC_D_ANSEL: d_ansel_ff <= wd;
                `PPC_D_WPU:   d_wpu_ff   <= wd;
                `PPC_D_ODCON: d_od_ff    <= wd;
                `PPC_D_SLEW:  d_slew_ff  <= wd;
                `PPC_D_INLVL: d_inlvl_ff <= wd;
                default: ;
            endcase
        end
    end

    // Read data is registered and holds until the next read strobe
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `PPC_RST_ZERO;
        end else if (ce && reg_rd) begin
            reg_rdata <= nxt_rdata;
        end
    end

    // Read decode; the pins register shows the synchronised pad levels
    always @* begin
        case (reg_addr)
            `PPC_A_WPU:   nxt_rdata = a_wpu_ff;
            `PPC_A_ODCON: nxt_rdata = a_od_ff;
            // Port B; the pins address shows pads, not the latch
            `PPC_B_PINS:  nxt_rdata = pb_sync_ff;
            `PPC_B_DIR:   nxt_rdata = b_dir_ff;
            `PPC_B_LAT:   nxt_rdata = b_lat_ff;
            `PPC_B_ANSEL: nxt_rdata = b_ansel_ff;
            `PPC_B_WPU:   nxt_rdata = b_wpu_ff;
            `PPC_B_ODCON: nxt_rdata = b_od_ff;
            `PPC_B_SLEW:  nxt_rdata = b_slew_ff;
            `PPC_B_INLVL: nxt_rdata = b_inlvl_ff;
            `PPC_B_HIDRV: nxt_rdata = b_hid_ff;
            // Port C
            `PPC_C_ANSEL: nxt_rdata = c_ansel_ff;
            `PPC_C_WPU:   nxt_rdata = c_wpu_ff;
            `PPC_C_ODCON: nxt_rdata = c_od_ff;
            `PPC_C_SLEW:  nxt_rdata = c_slew_ff;
            `PPC_C_INLVL: nxt_rdata = c_inlvl_ff;
            `PPC_C_RISE:  nxt_rdata = c_rise_ff;
            `PPC_C_FALL:  nxt_rdata = c_fall_ff;
            `PPC_C_FLAGS: nxt_rdata = c_flags_ff;
            // Port D
            `PPC_D_ANSEL: nxt_rdata = d_ansel_ff;
            `PPC_D_WPU:   nxt_rdata = d_wpu_ff;
            `PPC_D_ODCON: nxt_rdata = d_od_ff;
            `PPC_D_SLEW:  nxt_rdata = d_slew_ff;
            `PPC_D_INLVL: nxt_rdata = d_inlvl_ff;
            default:      nxt_rdata = `PPC_RST_ZERO;
        endcase
    end

    // Pin A5 pull-up is only usable with battery backup enabled; the bit
    // still reads back as written so software sees no surprise
    wire [7:0] a5_keep   = ~({7'h00, ~batt_backup_en} << `PPC_A5_BIT);
    wire [7:0] a_wpu_eff = a_wpu_ff & a5_keep;

    // Port A: direction and data come from the port logic on this clock

    assign pa_pullup  = pull_on(a_wpu_eff, pa_dir_in);
    assign pa_pad_oe  = drive_en(pa_dir_in, pa_data, a_od_ff);
    assign pa_pad_out = drive_lvl(pa_data, a_od_ff);

    // Port B: direction and latch are held in this block
    assign pb_pullup  = pull_on(b_wpu_ff, b_dir_ff);
    assign pb_pad_oe  = drive_en(b_dir_ff, b_lat_ff, b_od_ff);
    assign pb_pad_out = drive_lvl(b_lat_ff, b_od_ff);
    assign pb_analog     = b_ansel_ff;
    assign pb_slew       = b_slew_ff;
    assign pb_inlvl      = b_inlvl_ff;
    assign pb_high_drive = b_hid_ff;

    // Port C: change flags are a level; they stay set until software clears
    assign pc_pullup  = pull_on(c_wpu_ff, pc_dir_in);
    assign pc_pad_oe  = drive_en(pc_dir_in, pc_data, c_od_ff);
    assign pc_pad_out = drive_lvl(pc_data, c_od_ff);
    assign pc_analog     = c_ansel_ff;
    assign pc_slew       = c_slew_ff;
    assign pc_inlvl      = c_inlvl_ff;
    assign pc_change_any = |c_flags_ff;

    // Port D
    assign pd_pullup  = pull_on(d_wpu_ff, pd_dir_in);
    assign pd_pad_oe  = drive_en(pd_dir_in, pd_data, d_od_ff);
    assign pd_pad_out = drive_lvl(pd_data, d_od_ff);
    assign pd_analog     = d_ansel_ff;
    assign pd_slew       = d_slew_ff;
    assign pd_inlvl      = d_inlvl_ff;

endmodule // ppc_pad_config

`default_nettype wire
